// *** logic/reset_source_sequencer.sv ***
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_reset_source_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned PUD_CYCLES = `RSS_PUD_CYC
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire rss_cfg_s cfg,
    input wire rss_analog_s analog,
    input wire rss_core_s core,
    output rss_out_s ctl
);
    typedef struct packed {
        logic [2:0] syncPor;
        logic [2:0] syncBor;
        logic [2:0] syncRdy;
        logic [2:0] syncLp;
        logic [2:0] syncOsc;
        logic [2:0] syncMclr;
        logic porS;
        logic borS;
        logic rdyS;
        logic lpS;
        logic oscS;
        logic mclrS;
        logic [2:0] glitchCnt;
        logic mclrFilt;
        rss_state_e state;
        logic [31:0] cnt;
        logic pudDone;
        logic [7:0] cause;
        logic toN;
        logic pdN;
        logic swEn;
        logic lastPwr;
        // wake cause kept past the one-cycle core pulse
        logic irqWoke;
        logic ack;
        logic [31:0] rdat;
        rss_out_s out;
    } rss_st_s;

    rss_st_s st_r;
    rss_st_s st_nxt;

    logic mclrEn;
    logic borActive;
    logic borTrip;
    logic lpTrip;
    logic brownReq;
    logic stackRst;
    logic coreRst;
    logic wakeBlock;
    logic startBlock;
    logic wbWr;
    logic wbRd;
    logic [31:0] rdMux;

    always_comb
    begin
        st_nxt = st_r;
        // three-stage sync; change counts when stages 2 and 3 agree
        st_nxt.syncPor = {st_r.syncPor[1:0], analog.porReq};
        st_nxt.syncBor = {st_r.syncBor[1:0], analog.borLow};
        st_nxt.syncRdy = {st_r.syncRdy[1:0], analog.borReady};
        st_nxt.syncLp = {st_r.syncLp[1:0], analog.lpborLow};
        st_nxt.syncOsc = {st_r.syncOsc[1:0], analog.oscReady};
        st_nxt.syncMclr = {st_r.syncMclr[1:0], analog.masterClearPin};
        if (st_r.syncPor[1] == st_r.syncPor[2])
            st_nxt.porS = st_r.syncPor[2];
        if (st_r.syncBor[1] == st_r.syncBor[2])
            st_nxt.borS = st_r.syncBor[2];
        if (st_r.syncRdy[1] == st_r.syncRdy[2])
            st_nxt.rdyS = st_r.syncRdy[2];
        if (st_r.syncLp[1] == st_r.syncLp[2])
            st_nxt.lpS = st_r.syncLp[2];
        if (st_r.syncOsc[1] == st_r.syncOsc[2])
            st_nxt.oscS = st_r.syncOsc[2];
        if (st_r.syncMclr[1] == st_r.syncMclr[2])
            st_nxt.mclrS = st_r.syncMclr[2];

        // short pulses on the pin must persist before they count
        if (st_r.mclrS == st_r.mclrFilt)
            st_nxt.glitchCnt = '0;
        else if (st_r.glitchCnt == 3'(`RSS_GLITCH_CYC - 1))
        begin
            st_nxt.glitchCnt = '0;
            st_nxt.mclrFilt = st_r.mclrS;
        end
        else
            st_nxt.glitchCnt = st_r.glitchCnt + 3'h1;

        mclrEn = cfg.lowVoltageProgCfg | cfg.masterClearPinEnable;
        unique case (rss_bormode_e'(cfg.brownoutModeCfg))
            RSS_BOR_ON: borActive = 1'b1;
            RSS_BOR_NOSLP: borActive = st_r.state != RSS_ST_SLEEP;
            RSS_BOR_SW: borActive = st_r.swEn & st_r.rdyS;
            RSS_BOR_OFF: borActive = 1'b0;
        endcase
        borTrip = borActive & st_r.borS;
        lpTrip = ~cfg.lowpowerBrownoutEnableN & st_r.lpS;
        brownReq = borTrip | lpTrip;
        stackRst = cfg.stackFaultResetCfg & (core.stackOverflow | core.stackUnderflow);
        coreRst = core.watchdogTimeout | core.resetInstr | stackRst | core.progExit;

        // wake hold-off per brown-out mode
        unique case (rss_bormode_e'(cfg.brownoutModeCfg))
            RSS_BOR_NOSLP: wakeBlock = ~st_r.rdyS | st_r.borS;
            RSS_BOR_SW: wakeBlock = (st_r.swEn | st_r.lastPwr) & (~st_r.rdyS | st_r.borS);
            default: wakeBlock = 1'b0;
        endcase

        // start-up hold-off; software mode protects as soon as ready, no wait
        unique case (rss_bormode_e'(cfg.brownoutModeCfg))
            RSS_BOR_ON, RSS_BOR_NOSLP: startBlock = ~st_r.rdyS | st_r.borS;
            default: startBlock = 1'b0;
        endcase

        st_nxt.out.pcLoad = 1'b0;
        st_nxt.out.pcIncrement = 1'b0;
        st_nxt.out.pushReturn = 1'b0;
        st_nxt.out.borArmed = borActive;
        st_nxt.out.porRearm = (cfg.brownoutModeCfg == 2'(RSS_BOR_NOSLP)) & lpTrip;
        st_nxt.out.pullupEn = 1'b1;
        st_nxt.out.gpioIn = mclrEn ? 1'b1 : st_r.mclrS;

        if (st_r.porS)
        begin
            st_nxt.state = RSS_ST_HOLD;
            st_nxt.cause = `RSS_CAUSE_POR_VAL;
            {st_nxt.toN, st_nxt.pdN} = `RSS_STAT_POR_VAL;
            st_nxt.swEn = `RSS_SWEN_RST;
            st_nxt.lastPwr = 1'b1;
            st_nxt.pudDone = 1'b0;
            st_nxt.cnt = '0;
        end
        else if (brownReq)
        begin
            // brown-out pattern: stack cleared, ext/ri/wdt set, por kept, bor cleared
            st_nxt.state = RSS_ST_HOLD;
            st_nxt.cause[`RSS_CAUSE_OVF] = 1'b0;
            st_nxt.cause[`RSS_CAUSE_UNF] = 1'b0;
            st_nxt.cause[`RSS_CAUSE_WDT] = 1'b1;
            st_nxt.cause[`RSS_CAUSE_EXT] = 1'b1;
            st_nxt.cause[`RSS_CAUSE_RI] = 1'b1;
            st_nxt.cause[`RSS_CAUSE_BOR] = 1'b0;
            {st_nxt.toN, st_nxt.pdN} = `RSS_STAT_POR_VAL;
            st_nxt.swEn = `RSS_SWEN_RST;
            st_nxt.lastPwr = 1'b1;
            st_nxt.pudDone = 1'b0;
            st_nxt.cnt = '0;
        end
        else
        begin
            unique case (st_r.state)
                RSS_ST_HOLD:
                begin
                    st_nxt.cnt = '0;
                    st_nxt.state = cfg.powerUpDelayEnableN ? RSS_ST_WAIT : RSS_ST_PUD;
                    st_nxt.pudDone = cfg.powerUpDelayEnableN;
                end
                RSS_ST_PUD:
                begin
                    // runs regardless of master-clear
                    st_nxt.cnt = st_r.cnt + 32'h1;
                    if (st_r.cnt >= 32'(PUD_CYCLES - 1))
                    begin
                        st_nxt.pudDone = 1'b1;
                        st_nxt.state = RSS_ST_WAIT;
                    end
                end
                RSS_ST_WAIT:
                begin
                    st_nxt.cnt = '0;
                    if (st_r.oscS && !startBlock && !(mclrEn && !st_r.mclrFilt))
                        st_nxt.state = RSS_ST_DLY;
                end
                RSS_ST_DLY:
                begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                    if (mclrEn && !st_r.mclrFilt)
                        st_nxt.state = RSS_ST_WAIT;
                    else if (st_r.cnt == 32'(`RSS_EXEC_DLY - 1))
                    begin
                        st_nxt.state = RSS_ST_RUN;
                        st_nxt.out.pcLoad = 1'b1;
                        st_nxt.out.pcValue = `RSS_VEC_RESET;
                    end
                end
                RSS_ST_RUN:
                begin
                    if (mclrEn && !st_r.mclrFilt)
                    begin
                        st_nxt.cause[`RSS_CAUSE_EXT] = 1'b0;
                        st_nxt.lastPwr = 1'b0;
                        st_nxt.state = RSS_ST_WAIT;
                    end
                    else if (coreRst)
                    begin
                        st_nxt.lastPwr = 1'b0;
                        st_nxt.state = RSS_ST_WAIT;
                        if (core.watchdogTimeout)
                        begin
                            st_nxt.cause[`RSS_CAUSE_WDT] = 1'b0;
                            st_nxt.toN = 1'b0;
                        end
                        if (core.resetInstr)
                            st_nxt.cause[`RSS_CAUSE_RI] = 1'b0;
                        if (stackRst && core.stackOverflow)
                            st_nxt.cause[`RSS_CAUSE_OVF] = 1'b1;
                        if (stackRst && core.stackUnderflow)
                            st_nxt.cause[`RSS_CAUSE_UNF] = 1'b1;
                    end
                    else if (core.sleepEnter)
                    begin
                        st_nxt.pdN = 1'b0;
                        st_nxt.toN = 1'b1;
                        st_nxt.state = RSS_ST_SLEEP;
                    end
                    else if (core.watchdogClearInstr)
                    begin
                        st_nxt.toN = 1'b1;
                        st_nxt.pdN = 1'b1;
                    end
                end
                RSS_ST_SLEEP:
                begin
                    if (mclrEn && !st_r.mclrFilt)
                    begin
                        st_nxt.cause[`RSS_CAUSE_EXT] = 1'b0;
                        st_nxt.toN = 1'b1;
                        st_nxt.pdN = 1'b0;
                        st_nxt.lastPwr = 1'b0;
                        st_nxt.state = RSS_ST_WAIT;
                    end
                    else if (core.wdtWake || core.irqWake)
                    begin
                        st_nxt.irqWoke = core.irqWake;
                        if (core.wdtWake)
                            st_nxt.toN = 1'b0;
                        st_nxt.state = RSS_ST_WAKE;
                    end
                end
                RSS_ST_WAKE:
                begin
                    if (!wakeBlock)
                    begin
                        st_nxt.state = RSS_ST_RUN;
                        st_nxt.out.pcIncrement = 1'b1;
                        if (st_r.irqWoke && core.globalIrqEnable && st_r.toN)
                        begin
                            st_nxt.out.pushReturn = 1'b1;
                            st_nxt.out.pcLoad = 1'b1;
                            st_nxt.out.pcValue = `RSS_VEC_IRQ;
                        end
                    end
                end
            endcase
        end

        st_nxt.out.cpuRun = st_nxt.state == RSS_ST_RUN;
        st_nxt.out.cpuReset = st_nxt.state inside {RSS_ST_HOLD, RSS_ST_PUD, RSS_ST_WAIT,
            RSS_ST_DLY};

        // register access; software writes start no reset, except setting swEn in software brown-out mode while the supply is low
        wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack;
        wbRd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        if (wbWr && wb_sel_i[0])
        begin
            unique case (wb_adr_i[7:0])
                `RSS_ADDR_CAUSE: st_nxt.cause = {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
                `RSS_ADDR_BOR: st_nxt.swEn = wb_dat_i[`RSS_BOR_SWEN];
                default: ;
            endcase
        end
        rdMux = '0;
        unique case (wb_adr_i[7:0])
            `RSS_ADDR_CAUSE: rdMux[7:0] = st_r.cause;
            `RSS_ADDR_BOR: rdMux[7:0] = {st_r.swEn, 6'h00, st_r.rdyS};
            `RSS_ADDR_STAT: rdMux[`RSS_STAT_TO:`RSS_STAT_PD] = {st_r.toN, st_r.pdN};
            `RSS_ADDR_CFG: rdMux[1:0] = {~st_r.mclrS, mclrEn};
            default: rdMux = '0;
        endcase
        if (wbRd)
            st_nxt.rdat = rdMux;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
            st_r.state <= RSS_ST_HOLD;
            st_r.cause <= `RSS_CAUSE_POR_VAL;
            st_r.toN <= 1'b1;
            st_r.pdN <= 1'b1;
            st_r.swEn <= `RSS_SWEN_RST;
            st_r.lastPwr <= 1'b1;
            st_r.mclrS <= 1'b1;
            // idle pin level, so no false low edge follows reset
            st_r.syncMclr <= 3'h7;
            st_r.mclrFilt <= 1'b1;
            st_r.out.cpuReset <= 1'b1;
            st_r.out.pullupEn <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdat;
    assign ctl = st_r.out;
endmodule : rss_reset_source_sequencer

// *** shared/rss_regs.svh ***
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// register byte addresses
`define RSS_ADDR_CAUSE 8'h00
`define RSS_ADDR_BOR 8'h04
`define RSS_ADDR_STAT 8'h08
`define RSS_ADDR_CFG 8'h0c
// cause register fields
`define RSS_CAUSE_BOR 0
`define RSS_CAUSE_POR 1
`define RSS_CAUSE_RI 2
`define RSS_CAUSE_EXT 3
`define RSS_CAUSE_WDT 4
`define RSS_CAUSE_UNF 6
`define RSS_CAUSE_OVF 7
// status register fields
`define RSS_STAT_PD 3
`define RSS_STAT_TO 4
// brown-out control register fields
`define RSS_BOR_RDY 0
`define RSS_BOR_SWEN 7
// reset values
`define RSS_CAUSE_POR_VAL 8'h1c
`define RSS_STAT_POR_VAL 2'h3
`define RSS_SWEN_RST 1'b1
// timing
`define RSS_CLK_MHZ 125
`define RSS_PUD_MS 64
`define RSS_PUD_CYC (`RSS_PUD_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_EXEC_DLY 10
`define RSS_GLITCH_CYC 4
// vectors
`define RSS_VEC_RESET 16'h0000
`define RSS_VEC_IRQ 16'h0004
`endif

// *** shared/rss_pkg.sv ***
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_BOR_OFF = 2'h0,
        RSS_BOR_SW = 2'h1,
        RSS_BOR_NOSLP = 2'h2,
        RSS_BOR_ON = 2'h3
    } rss_bormode_e;

    typedef enum {
        RSS_ST_HOLD,
        RSS_ST_PUD,
        RSS_ST_WAIT,
        RSS_ST_DLY,
        RSS_ST_RUN,
        RSS_ST_SLEEP,
        RSS_ST_WAKE
    } rss_state_e;

    typedef struct packed {
        logic [1:0] brownoutModeCfg;
        logic lowpowerBrownoutEnableN;
        logic masterClearPinEnable;
        logic lowVoltageProgCfg;
        logic powerUpDelayEnableN;
        logic stackFaultResetCfg;
    } rss_cfg_s;

    typedef struct packed {
        logic porReq;
        logic borLow;
        logic borReady;
        logic lpborLow;
        logic oscReady;
        logic masterClearPin;
    } rss_analog_s;

    typedef struct packed {
        logic watchdogTimeout;
        logic watchdogClearInstr;
        logic resetInstr;
        logic stackOverflow;
        logic stackUnderflow;
        logic progExit;
        logic sleepEnter;
        logic wdtWake;
        logic irqWake;
        logic globalIrqEnable;
    } rss_core_s;

    typedef struct packed {
        logic cpuReset;
        logic cpuRun;
        logic pcLoad;
        logic [15:0] pcValue;
        logic pcIncrement;
        logic pushReturn;
        logic borArmed;
        logic porRearm;
        logic pullupEn;
        logic gpioIn;
    } rss_out_s;
endpackage : rss_pkg

// *** dv/rss_checker.sv ***
`timescale 1ns/1ps
module rss_checker
    import rss_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire rss_cfg_s cfg,
    input wire rss_analog_s analog,
    input wire rss_core_s core,
    input wire rss_out_s ctl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic take;
    logic pinOn;
    logic unmapped;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign pinOn = cfg.masterClearPinEnable || cfg.lowVoltageProgCfg;
    assign unmapped = wb_adr_i > 32'h0000000c || wb_adr_i[1:0] != 2'h0;
    // long enough to pass both synchroniser and glitch filter
    sequence sPinHeldLow;
        (pinOn && !analog.masterClearPin) [*8];
    endsequence
    sequence sPinFreeHigh;
        (!pinOn && analog.masterClearPin) [*8];
    endsequence
    sequence sColdStart;
        ctl.pcLoad && ctl.pcValue == 16'h0000;
    endsequence
    sequence sIrqLoad;
        ctl.pcLoad && ctl.pcValue == 16'h0004;
    endsequence
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_UNMAPPED_ZERO: assert property (take && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_PIN_HOLD: assert property (sPinHeldLow |-> ##[0:4] ctl.cpuReset)
        else $error("held pin did not reset");
    AST_GPIO_FOLLOW: assert property (sPinFreeHigh |-> ##[0:4] ctl.gpioIn)
        else $error("general input not following pin");
    AST_BOR_OFF: assert property ((cfg.brownoutModeCfg == RSS_BOR_OFF) [*2] |-> !ctl.borArmed)
        else $error("brown-out armed in off mode");
    AST_COLD_VECTOR: assert property ($fell(ctl.cpuReset) |-> ##[0:2] sColdStart)
        else $error("restart not at address zero");
    AST_IRQ_VECTOR: assert property (ctl.pushReturn |-> ##[0:2] sIrqLoad)
        else $error("push without interrupt vector");
    AST_RUN_GATED: assert property (ctl.cpuRun |-> !ctl.cpuReset)
        else $error("running while held in reset");
endmodule : rss_checker

bind rss_reset_source_sequencer rss_checker u_chk (.clk, .arst_n, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cfg, .analog, .core,
    .ctl);

// *** dv/rss_partner.sv ***
`timescale 1ns/1ps
module rss_partner
    import rss_pkg::*;
#(
    parameter int OSC_DLY = 6
)(
    input wire logic clk,
    input wire logic powerOn,
    input wire logic supplyLow,
    input wire logic lpSupplyLow,
    input wire logic pinLow,
    output rss_analog_s analog
);
    int oscCnt = 0;
    // detector and oscillator need time after each power-up, never ready at once
    always @(posedge clk)
    begin
        if (!powerOn)
            oscCnt <= 0;
        else if (oscCnt < OSC_DLY)
            oscCnt <= oscCnt + 1;
    end
    always_comb
    begin
        analog.porReq = !powerOn;
        analog.borLow = supplyLow;
        analog.borReady = oscCnt >= 2;
        analog.lpborLow = lpSupplyLow;
        analog.oscReady = oscCnt == OSC_DLY;
        // weak pull-up: released pin reads high
        analog.masterClearPin = !pinLow;
    end
endmodule : rss_partner

// *** dv/reset_source_sequencer_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errCount++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module reset_source_sequencer_bench
    import rss_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] adr = '0, datI = '0, rd, datO;
    logic [3:0] sel = 4'hf;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, incSeen;
    logic powerOn = 1'b0, supLow = 1'b0, lpLow = 1'b0, pinLow = 1'b0;
    logic [15:0] pcSeen;
    rss_cfg_s cfg = '{RSS_BOR_ON, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    // interrupts globally enabled throughout
    rss_core_s core = 10'h001;
    rss_analog_s analog;
    rss_out_s ctl;
    int errCount = 0, checksDone = 0, tick = 0, n;
    rss_reset_source_sequencer #(.PUD_CYCLES(20)) u_dut (.clk, .arst_n, .wb_adr_i(adr),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .cfg, .analog, .core, .ctl);
    rss_partner u_far (.clk, .powerOn, .supplyLow(supLow), .lpSupplyLow(lpLow), .pinLow,
        .analog);
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        tick <= tick + 1;
        if (tick == 30000)
        begin
            errCount++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        adr <= {24'h0, a};
        datI <= {24'h0, d};
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 40);
        `CHK("ack", 1'b1, ack)
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rdReg(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rdReg
    task automatic pulse(input int b);
        core[b] <= 1'b1;
        @(posedge clk);
        core[b] <= 1'b0;
    endtask : pulse
    task automatic waitRst;
        for (int c = 0; c < 60 && ctl.cpuReset !== 1'b1; c++)
            @(posedge clk);
    endtask : waitRst
    task automatic waitRun(output int c);
        for (c = 0; c < 400 && ctl.cpuRun !== 1'b1; c++)
            @(posedge clk);
    endtask : waitRun
    task automatic watchPc;
        pcSeen = 16'hffff;
        incSeen = 1'b0;
        repeat (30)
        begin
            @(posedge clk);
            if (ctl.pcLoad === 1'b1)
                pcSeen = ctl.pcValue;
            if (ctl.pcIncrement === 1'b1)
                incSeen = 1'b1;
        end
    endtask : watchPc
    task automatic tPowerOn;
        waitRun(n);
        `CHK("delay", 1'b1, n >= 20)
        rdReg(8'h00);
        `CHK("cause", 8'h1c, rd[7:0])
        rdReg(8'h08);
        `CHK("status", 8'h18, rd[7:0])
        rdReg(8'h04);
        `CHK("borctl", 8'h81, rd[7:0])
        rdReg(8'h40);
        `CHK("unmapped", 32'h0, rd)
    endtask : tPowerOn
    task automatic tSleep;
        pulse(3);
        repeat (5) @(posedge clk);
        pulse(1);
        watchPc;
        `CHK("irq vector", 16'h0004, pcSeen)
        rdReg(8'h08);
        `CHK("status irq", 8'h10, rd[7:0])
        pulse(3);
        repeat (5) @(posedge clk);
        pulse(2);
        watchPc;
        `CHK("wdt wake", 1'b1, incSeen)
        rdReg(8'h08);
        `CHK("status wdt", 8'h00, rd[7:0])
    endtask : tSleep
    task automatic tCauses;
        pulse(7);
        waitRst;
        waitRun(n);
        rdReg(8'h00);
        `CHK("ri", 8'h18, rd[7:0])
        pulse(6);
        repeat (30) @(posedge clk);
        `CHK("stack off", 1'b1, ctl.cpuRun)
        cfg.stackFaultResetCfg <= 1'b1;
        pulse(6);
        waitRst;
        waitRun(n);
        rdReg(8'h00);
        `CHK("ovf", 8'h98, rd[7:0])
        bus(1'b1, 8'h00, 8'hc0);
        repeat (20) @(posedge clk);
        `CHK("soft set run", 1'b1, ctl.cpuRun)
        rdReg(8'h00);
        `CHK("soft set", 8'hc0, rd[7:0])
        bus(1'b1, 8'h00, 8'h1f);
        pulse(8);
        @(posedge clk);
        pulse(9);
        waitRst;
        waitRun(n);
        rdReg(8'h00);
        `CHK("wdt", 8'h0f, rd[7:0])
        rdReg(8'h08);
        `CHK("wdt status", 8'h08, rd[7:0])
        pulse(4);
        waitRst;
        `CHK("prog exit", 1'b1, ctl.cpuReset)
        waitRun(n);
    endtask : tCauses
    task automatic tPin;
        bus(1'b1, 8'h00, 8'h1f);
        pinLow <= 1'b1;
        repeat (2) @(posedge clk);
        pinLow <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("glitch", 1'b1, ctl.cpuRun)
        pinLow <= 1'b1;
        waitRst;
        repeat (40) @(posedge clk);
        pinLow <= 1'b0;
        waitRun(n);
        `CHK("exec delay", 1'b1, n >= 10 && n <= 25)
        rdReg(8'h00);
        `CHK("ext", 8'h17, rd[7:0])
        cfg.masterClearPinEnable <= 1'b0;
        repeat (12) @(posedge clk);
        pinLow <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("pin off", 2'h2, {ctl.cpuRun, ctl.gpioIn})
        rdReg(8'h0c);
        `CHK("pin stat", 8'h02, rd[7:0])
        cfg.lowVoltageProgCfg <= 1'b1;
        waitRst;
        `CHK("lvp pin", 1'b1, ctl.cpuReset)
        pinLow <= 1'b0;
        waitRun(n);
    endtask : tPin
    task automatic tBrownout;
        cfg.lowpowerBrownoutEnableN <= 1'b1;
        lpLow <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("lp off", 1'b1, ctl.cpuRun)
        cfg.lowpowerBrownoutEnableN <= 1'b0;
        waitRst;
        `CHK("lp trip", 1'b1, ctl.cpuReset)
        lpLow <= 1'b0;
        waitRun(n);
        `CHK("lp delay", 1'b1, n >= 20)
        rdReg(8'h00);
        `CHK("bor cause", 8'h1e, rd[7:0])
        cfg.brownoutModeCfg <= RSS_BOR_OFF;
        supLow <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("bor off", 2'h2, {ctl.cpuRun, ctl.borArmed})
        supLow <= 1'b0;
        repeat (10) @(posedge clk);
        cfg.brownoutModeCfg <= RSS_BOR_SW;
        bus(1'b1, 8'h04, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("sw off", 1'b0, ctl.borArmed)
        bus(1'b1, 8'h04, 8'h80);
        repeat (3) @(posedge clk);
        `CHK("sw on", 1'b1, ctl.borArmed)
        cfg.brownoutModeCfg <= RSS_BOR_NOSLP;
        pulse(3);
        repeat (5) @(posedge clk);
        `CHK("sleep off", 1'b0, ctl.borArmed)
        pulse(1);
        watchPc;
        `CHK("wake on", 1'b1, ctl.borArmed)
        cfg.brownoutModeCfg <= RSS_BOR_ON;
        pulse(3);
        repeat (5) @(posedge clk);
        `CHK("sleep on", 1'b1, ctl.borArmed)
        pulse(1);
        watchPc;
    endtask : tBrownout
    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        powerOn <= 1'b1;
        tPowerOn;
        tSleep;
        tCauses;
        tPin;
        tBrownout;
        report_and_stop;
    end
endmodule : reset_source_sequencer_bench
